// file: inc/tlipv_pkg.sv
/*
  Package for the two-level interrupt priority and vectoring block.
  Assumes one pclk domain, APB register access, core-supplied cycle strobes.
*/
// Functional notes
// - Priority bit clear low, set high
// - Global enable off blocks all, else per-source
// - Each source has its own fixed vector
// - First priority register holds six source bits
// - Second priority register holds ccu-side bits
// - Low routine preempted only by high request
// - High routine in progress blocks every vector
// - High level wins over low level
// - Equal level resolved by six-row polling order
// - Within a row first column wins
// - Sample flags at phase, evaluate next cycle
// - Poll every machine cycle on previous samples
// - Enabled unblocked request causes vector long call
// - Equal or higher level in progress blocks
// - Vector only at instruction final cycle
// - Exit or register write delays one instruction
// - No memory of denied requests
// - High request vectored without lower instruction first
// - Clear external flags only if edge-triggered
// - Call pushes counter only, loads vector
// - Interrupt exit ends current level in progress
// - Plain return leaves in-progress state set
// - Requests formed from peripheral flag bytes
package tlipv_pkg;
  localparam int NSRC = 12;
  localparam int AW = 12;
  // Register indexes, byte address is index times four
  localparam logic [9:0] IDX_ENABLE_LOW = 10'h0a8;
  localparam logic [9:0] IDX_ENABLE_CCU = 10'h0a9;
  localparam logic [9:0] IDX_PRIO_LOW = 10'h0b8;
  localparam logic [9:0] IDX_PRIO_CCU = 10'h0b9;
  localparam logic [9:0] IDX_EDGE_MODE = 10'h0c0;
  localparam logic [9:0] IDX_STATUS = 10'h0c1;
  // Reset values
  localparam logic [7:0] RST_PRIO = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [2:0] RST_EDGE = 3'h0;
  // Field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam logic [7:0] PRIO_LOW_MASK = 8'h3f;
  localparam logic [7:0] PRIO_CCU_MASK = 8'h3f;
  localparam logic [7:0] ENABLE_LOW_MASK = 8'hbf;
  localparam logic [7:0] ENABLE_CCU_MASK = 8'h3f;
  localparam int CC_MATCH_LSB = 0;
  localparam int CMP_T1_COMPARE_BIT = 6;
  localparam int CMP_T1_PERIOD_BIT = 7;
  // Sources in polling order, row by row, first column first
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_ADC = 4'h1;
  localparam logic [3:0] SRC_TIMER0 = 4'h2;
  localparam logic [3:0] SRC_EXT2 = 4'h3;
  localparam logic [3:0] SRC_EXT1 = 4'h4;
  localparam logic [3:0] SRC_CCU_TRAP = 4'h5;
  localparam logic [3:0] SRC_TIMER1 = 4'h6;
  localparam logic [3:0] SRC_CMP_T2 = 4'h7;
  localparam logic [3:0] SRC_SERIAL = 4'h8;
  localparam logic [3:0] SRC_CC_MATCH = 4'h9;
  localparam logic [3:0] SRC_TIMER2 = 4'ha;
  localparam logic [3:0] SRC_CMP_T1 = 4'hb;
  // Vectors indexed by source
  localparam logic [NSRC*16-1:0] VECTORS = {
    16'h006b, 16'h002b, 16'h0063, 16'h0023, 16'h005b, 16'h001b,
    16'h0053, 16'h0013, 16'h004b, 16'h000b, 16'h0043, 16'h0003};

  typedef struct packed {
    logic ext0_request_flag;
    logic ext1_request_flag;
    logic ext2_request_bit;
    logic timer0_overflow_flag;
    logic timer1_overflow_flag;
    logic timer2_overflow_flag;
    logic timer2_external_flag;
    logic serial_receive_done;
    logic serial_transmit_done;
    logic converter_done_flag;
    logic ccu_trap_flag;
    logic commutation_error_flag;
    logic cmp_timer2_period_flag;
    logic [7:0] cc_flag_byte;
  } tlipv_flags_s;

  typedef struct packed {
    logic vector_long_call;
    logic [15:0] vector_addr;
    logic [3:0] vector_src;
    logic [2:0] ext_flag_clear;
  } tlipv_vec_s;
endpackage

// file: logic/tlipv_ctrl.sv
/*
  Two-level interrupt priority controller with polling and vectoring.
  Assumes core strobes flag_sample_phase and machine_cycle_end once per
  machine cycle, and an APB master on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module tlipv_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tlipv_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core sequencer
  input wire logic flag_sample_phase,
  input wire logic machine_cycle_end,
  input wire logic instr_final_cycle,
  input wire logic interrupt_exit_instruction,
  input wire logic plain_subroutine_exit,
  input wire logic irq_reg_write,
  // Peripheral flags
  input wire tlipv_pkg::tlipv_flags_s flags,
  // Vector output
  output tlipv_pkg::tlipv_vec_s vec,
  output logic [1:0] in_progress
);
  typedef struct packed {
    logic [7:0] prio_low;
    logic [7:0] prio_ccu;
    logic [7:0] en_low;
    logic [7:0] en_ccu;
    logic [2:0] edge_mode;
    logic [11:0] sampled;
    logic [11:0] polled;
    logic [1:0] inprog;
    logic hold_off;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    tlipv_pkg::tlipv_vec_s vec;
  } tlipv_state_s;

  tlipv_state_s st_q, st_d;

  function automatic logic [11:0] form_requests(input tlipv_pkg::tlipv_flags_s f);
    logic [11:0] r;
    r = '0;
    r[tlipv_pkg::SRC_EXT0] = f.ext0_request_flag;
    r[tlipv_pkg::SRC_ADC] = f.converter_done_flag;
    r[tlipv_pkg::SRC_TIMER0] = f.timer0_overflow_flag;
    r[tlipv_pkg::SRC_EXT2] = f.ext2_request_bit;
    r[tlipv_pkg::SRC_EXT1] = f.ext1_request_flag;
    r[tlipv_pkg::SRC_CCU_TRAP] = f.ccu_trap_flag | f.commutation_error_flag;
    r[tlipv_pkg::SRC_TIMER1] = f.timer1_overflow_flag;
    r[tlipv_pkg::SRC_CMP_T2] = f.cmp_timer2_period_flag;
    r[tlipv_pkg::SRC_SERIAL] = f.serial_receive_done | f.serial_transmit_done;
    r[tlipv_pkg::SRC_CC_MATCH] = |f.cc_flag_byte[tlipv_pkg::CC_MATCH_LSB +: 6];
    r[tlipv_pkg::SRC_TIMER2] = f.timer2_overflow_flag | f.timer2_external_flag;
    r[tlipv_pkg::SRC_CMP_T1] = f.cc_flag_byte[tlipv_pkg::CMP_T1_PERIOD_BIT] |
                               f.cc_flag_byte[tlipv_pkg::CMP_T1_COMPARE_BIT];
    return r;
  endfunction

  // Map register bits to sources in polling order
  function automatic logic [11:0] by_source(input logic [7:0] lo, input logic [7:0] cc);
    logic [11:0] m;
    m = '0;
    m[tlipv_pkg::SRC_EXT0] = lo[0];
    m[tlipv_pkg::SRC_TIMER0] = lo[1];
    m[tlipv_pkg::SRC_EXT1] = lo[2];
    m[tlipv_pkg::SRC_TIMER1] = lo[3];
    m[tlipv_pkg::SRC_SERIAL] = lo[4];
    m[tlipv_pkg::SRC_TIMER2] = lo[5];
    m[tlipv_pkg::SRC_ADC] = cc[0];
    m[tlipv_pkg::SRC_EXT2] = cc[1];
    m[tlipv_pkg::SRC_CCU_TRAP] = cc[2];
    m[tlipv_pkg::SRC_CMP_T2] = cc[3];
    m[tlipv_pkg::SRC_CC_MATCH] = cc[4];
    m[tlipv_pkg::SRC_CMP_T1] = cc[5];
    return m;
  endfunction

  // Lowest index set wins
  function automatic logic [3:0] first_set(input logic [11:0] m);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = tlipv_pkg::NSRC - 1; i >= 0; i--) begin
      if (m[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  logic [11:0] req_now;
  logic [11:0] enabled;
  logic [11:0] level_high;
  logic [11:0] cand_high;
  logic [11:0] cand_low;
  logic win_found;
  logic win_high;
  logic [3:0] win_src;
  logic level_blocked;
  logic poll_now;
  logic fire;
  logic apb_setup;
  logic apb_write;
  logic [9:0] widx;
  logic irq_cfg_write;

  assign req_now = form_requests(flags);
  assign enabled = st_q.en_low[tlipv_pkg::GLOBAL_EN_BIT] ?
                   by_source(st_q.en_low, st_q.en_ccu) : 12'h000;
  assign level_high = by_source(st_q.prio_low, st_q.prio_ccu);
  assign cand_high = st_q.polled & enabled & level_high;
  assign cand_low = st_q.polled & enabled & ~level_high;
  assign win_high = |cand_high;
  assign win_found = |(st_q.polled & enabled);
  // polling order by index, first column first
  assign win_src = win_high ? first_set(cand_high) : first_set(cand_low);
  assign level_blocked = st_q.inprog[1] | (st_q.inprog[0] & ~win_high);
  assign poll_now = machine_cycle_end & instr_final_cycle;
  assign fire = poll_now & win_found & ~level_blocked & ~st_q.hold_off &
                ~interrupt_exit_instruction & ~irq_cfg_write;

  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite & st_q.ready;
  assign widx = paddr[tlipv_pkg::AW-1:2];
  assign irq_cfg_write = irq_reg_write | (apb_write &
                         (widx == tlipv_pkg::IDX_ENABLE_LOW ||
                          widx == tlipv_pkg::IDX_ENABLE_CCU ||
                          widx == tlipv_pkg::IDX_PRIO_LOW ||
                          widx == tlipv_pkg::IDX_PRIO_CCU));

  always_comb begin
    st_d = st_q;
    st_d.vec.vector_long_call = 1'b0;
    st_d.vec.ext_flag_clear = 3'h0;
    if (flag_sample_phase) begin
      st_d.sampled = req_now;
    end
    // poll previous cycle samples, nothing kept
    if (machine_cycle_end) begin
      st_d.polled = st_q.sampled;
    end
    // exit or config write holds one instruction
    if (interrupt_exit_instruction | irq_cfg_write) begin
      st_d.hold_off = 1'b1;
    end else if (poll_now) begin
      st_d.hold_off = 1'b0;
    end
    // exit clears highest level, plain return ignored
    if (interrupt_exit_instruction & ~plain_subroutine_exit) begin
      if (st_q.inprog[1]) begin
        st_d.inprog[1] = 1'b0;
      end else begin
        st_d.inprog[0] = 1'b0;
      end
    end
    if (fire) begin
      st_d.inprog[win_high] = 1'b1;
      st_d.vec.vector_long_call = 1'b1;
      st_d.vec.vector_src = win_src;
      // fixed vector, counter pushed by core
      st_d.vec.vector_addr = tlipv_pkg::VECTORS[win_src*16 +: 16];
      st_d.vec.ext_flag_clear[0] = (win_src == tlipv_pkg::SRC_EXT0) & st_q.edge_mode[0];
      st_d.vec.ext_flag_clear[1] = (win_src == tlipv_pkg::SRC_EXT1) & st_q.edge_mode[1];
      st_d.vec.ext_flag_clear[2] = (win_src == tlipv_pkg::SRC_EXT2) & st_q.edge_mode[2];
    end
    // APB access, answered in the first access cycle
    st_d.ready = apb_setup;
    if (apb_setup) begin
      st_d.rdata = 32'h0000_0000;
      st_d.slverr = 1'b0;
      unique case (widx)
        tlipv_pkg::IDX_ENABLE_LOW: st_d.rdata[7:0] = st_q.en_low;
        tlipv_pkg::IDX_ENABLE_CCU: st_d.rdata[7:0] = st_q.en_ccu;
        tlipv_pkg::IDX_PRIO_LOW: st_d.rdata[7:0] = st_q.prio_low;
        tlipv_pkg::IDX_PRIO_CCU: st_d.rdata[7:0] = st_q.prio_ccu;
        tlipv_pkg::IDX_EDGE_MODE: st_d.rdata[2:0] = st_q.edge_mode;
        tlipv_pkg::IDX_STATUS: st_d.rdata[11:0] = {st_q.polled[7:0], st_q.hold_off,
                                                   1'b0, st_q.inprog};
        default: st_d.slverr = 1'b1;
      endcase
    end
    if (apb_write) begin
      unique case (widx)
        tlipv_pkg::IDX_ENABLE_LOW: st_d.en_low = pwdata[7:0] & tlipv_pkg::ENABLE_LOW_MASK;
        tlipv_pkg::IDX_ENABLE_CCU: st_d.en_ccu = pwdata[7:0] & tlipv_pkg::ENABLE_CCU_MASK;
        tlipv_pkg::IDX_PRIO_LOW: st_d.prio_low = pwdata[7:0] & tlipv_pkg::PRIO_LOW_MASK;
        tlipv_pkg::IDX_PRIO_CCU: st_d.prio_ccu = pwdata[7:0] & tlipv_pkg::PRIO_CCU_MASK;
        tlipv_pkg::IDX_EDGE_MODE: st_d.edge_mode = pwdata[2:0];
        default: st_d.edge_mode = st_q.edge_mode;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.prio_low <= tlipv_pkg::RST_PRIO;
      st_q.prio_ccu <= tlipv_pkg::RST_PRIO;
      st_q.en_low <= tlipv_pkg::RST_ENABLE;
      st_q.en_ccu <= tlipv_pkg::RST_ENABLE;
      st_q.edge_mode <= tlipv_pkg::RST_EDGE;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.slverr;
  assign vec = st_q.vec;
  assign in_progress = st_q.inprog;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_GLOBAL_OFF: assert property (
    !st_q.en_low[tlipv_pkg::GLOBAL_EN_BIT] |=> !vec.vector_long_call)
    else $error("Vector issued with global enable off");
  AST_HIGH_BLOCKS_ALL: assert property (
    st_q.inprog[1] |=> !vec.vector_long_call)
    else $error("Vector issued during high routine");
  AST_LOW_NOT_PREEMPT_LOW: assert property (
    (st_q.inprog[0] && fire) |-> win_high)
    else $error("Low request preempted low routine");
  AST_FINAL_CYCLE: assert property (
    vec.vector_long_call |-> $past(machine_cycle_end) && $past(instr_final_cycle))
    else $error("Vector outside final cycle");
  AST_HIGH_WINS: assert property (
    (fire && |cand_high) |=> level_high[vec.vector_src])
    else $error("Low request chosen over high");
  AST_SETS_LEVEL: assert property (
    fire |=> st_q.inprog[$past(win_high)])
    else $error("In-progress bit not set");
  AST_EXIT_HOLD: assert property (
    interrupt_exit_instruction |=> st_q.hold_off && !vec.vector_long_call)
    else $error("Vector too soon after exit");
  AST_HOLD_POLL: assert property (
    (st_q.hold_off && poll_now) |=> !vec.vector_long_call)
    else $error("Vector during hold-off poll");
  AST_HIGH_PREEMPTS: assert property (
    (poll_now && |cand_high && !st_q.inprog[1] && !st_q.hold_off &&
     !interrupt_exit_instruction && !irq_cfg_write) |=>
      vec.vector_long_call && in_progress[1])
    else $error("High request not vectored at once");
  AST_EXT0_CLEAR: assert property (
    (fire && win_src == tlipv_pkg::SRC_EXT0) |=>
      vec.ext_flag_clear[0] == st_q.edge_mode[0])
    else $error("External flag clear wrong");
  AST_VECTOR_ADDR: assert property (
    (fire && win_src == tlipv_pkg::SRC_EXT0) |=> vec.vector_addr == 16'h0003)
    else $error("Wrong vector address");
  AST_POLL_OLD: assert property (
    machine_cycle_end |=> st_q.polled == $past(st_q.sampled))
    else $error("Polling did not take previous samples");
endmodule
`default_nettype wire

// file: verification/tlipv_core_model.sv
/*
  Core sequencer model: machine-cycle strobes, instruction end, returns.
  Assumes a free running pclk; the bench asks for a return by level.
*/
`timescale 1ns/1ns
`default_nettype none
module tlipv_core_model #(
  parameter int MC_LEN = 6,
  parameter int INSTR_MC = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench requests
  input wire logic exit_req,
  input wire logic ret_plain,
  // Core strobes
  output logic flag_sample_phase,
  output logic machine_cycle_end,
  output logic instr_final_cycle,
  output logic interrupt_exit_instruction,
  output logic plain_subroutine_exit
);
  localparam logic [2:0] PH_PRE = 3'(MC_LEN - 2);
  localparam logic [2:0] PH_LAST = 3'(MC_LEN - 1);
  logic [2:0] ph_q;
  logic [1:0] mc_q;
  logic ret_now;
  assign instr_final_cycle = (mc_q == 2'(INSTR_MC - 1));
  assign ret_now = exit_req && (ph_q == PH_PRE) && instr_final_cycle;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 3'h0;
      mc_q <= 2'h0;
      flag_sample_phase <= 1'b0;
      machine_cycle_end <= 1'b0;
      interrupt_exit_instruction <= 1'b0;
      plain_subroutine_exit <= 1'b0;
    end else begin
      ph_q <= (ph_q == PH_LAST) ? 3'h0 : ph_q + 3'h1;
      flag_sample_phase <= (ph_q == 3'h2);
      machine_cycle_end <= (ph_q == PH_PRE);
      if (machine_cycle_end) begin
        mc_q <= instr_final_cycle ? 2'h0 : mc_q + 2'h1;
      end
      interrupt_exit_instruction <= ret_now && !ret_plain;
      plain_subroutine_exit <= ret_now && ret_plain;
    end
  end
endmodule
`default_nettype wire

// file: verification/tlipv_ctrl_tb.sv
/*
  Testbench for the interrupt priority controller: APB tasks, call checks.
  Assumes the core model supplies machine-cycle strobes and returns.
*/
`timescale 1ns/1ns
`default_nettype none
module tlipv_ctrl_tb;
  localparam int LIMIT = 20000;
  localparam logic [11:0] A_ENL = {tlipv_pkg::IDX_ENABLE_LOW, 2'b00};
  localparam logic [11:0] A_ENC = {tlipv_pkg::IDX_ENABLE_CCU, 2'b00};
  localparam logic [11:0] A_PRL = {tlipv_pkg::IDX_PRIO_LOW, 2'b00};
  localparam logic [11:0] A_PRC = {tlipv_pkg::IDX_PRIO_CCU, 2'b00};
  localparam logic [11:0] A_EDG = {tlipv_pkg::IDX_EDGE_MODE, 2'b00};
  localparam logic [11:0] A_STS = {tlipv_pkg::IDX_STATUS, 2'b00};
  localparam logic [20:0] F_EXT0 = 21'h100000;
  localparam logic [20:0] F_ADC = 21'h000800;
  localparam logic [20:0] F_T0 = 21'h020000;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, got, fsp, mce, ifc, exi, pse;
  logic irq_reg_write = 1'b0, exit_req = 1'b0, ret_plain = 1'b0;
  tlipv_pkg::tlipv_flags_s flags = '0;
  tlipv_pkg::tlipv_vec_s vec;
  logic [1:0] in_progress;
  int miscompares = 0, n_compared = 0, cyc = 0;
  logic [11:0] regs [6] = '{A_ENL, A_ENC, A_PRL, A_PRC, A_EDG, A_STS};
  logic [15:0] vtab [12] = '{16'h0003, 16'h0043, 16'h000b, 16'h004b, 16'h0013, 16'h0053,
    16'h001b, 16'h005b, 16'h0023, 16'h0063, 16'h002b, 16'h006b};
  int fbit [2][12] = '{'{20, 11, 17, 18, 19, 10, 16, 8, 13, 5, 15, 7},
    '{20, 11, 17, 18, 19, 9, 16, 8, 12, 0, 14, 6}};
  tlipv_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flag_sample_phase(fsp), .machine_cycle_end(mce),
    .instr_final_cycle(ifc), .interrupt_exit_instruction(exi), .plain_subroutine_exit(pse),
    .irq_reg_write(irq_reg_write), .flags(flags), .vec(vec), .in_progress(in_progress));
  tlipv_core_model core (.pclk(pclk), .presetn(presetn), .exit_req(exit_req),
    .ret_plain(ret_plain), .flag_sample_phase(fsp), .machine_cycle_end(mce),
    .instr_final_cycle(ifc), .interrupt_exit_instruction(exi), .plain_subroutine_exit(pse));
  always #2 pclk = ~pclk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_flags(input logic [20:0] v);
    @(posedge pclk);
    flags <= tlipv_pkg::tlipv_flags_s'(v);
  endtask
  task automatic no_call(input string what);
    got = 1'b0;
    repeat (100) begin
      @(posedge pclk);
      if (vec.vector_long_call === 1'b1) got = 1'b1;
    end
    check(what, 32'(got), 32'h0);
  endtask
  task automatic serve(input logic [20:0] v, input int s, input logic [2:0] clr,
      input logic [1:0] ip);
    int n;
    set_flags(v);
    n = 0;
    got = 1'b0;
    while (got !== 1'b1 && n < 150) begin
      @(posedge pclk);
      got = vec.vector_long_call;
      n++;
    end
    check("call", 32'(got), 32'h1);
    check("vector address", 32'(vec.vector_addr), 32'(vtab[s]));
    check("source", 32'(vec.vector_src), 32'(s));
    check("flag clear", 32'(vec.ext_flag_clear), 32'(clr));
    check("in progress", 32'(in_progress), 32'(ip));
  endtask
  task automatic do_ret(input logic plain);
    int n;
    @(posedge pclk);
    ret_plain <= plain;
    exit_req <= 1'b1;
    n = 0;
    got = 1'b0;
    while (got !== 1'b1 && n < 100) begin
      @(posedge pclk);
      got = plain ? pse : exi;
      n++;
    end
    check("return seen", 32'(got), 32'h1);
    exit_req <= 1'b0;
    @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[k]) begin
      apb(1'b0, regs[k], 32'h0);
      check("reset value", rd, 32'h0);
    end
    apb(1'b1, A_PRL, 32'hff);
    apb(1'b0, A_PRL, 32'h0);
    check("priority low", rd, 32'h3f);
    apb(1'b1, A_PRC, 32'hff);
    apb(1'b0, A_PRC, 32'h0);
    check("priority ccu", rd, 32'h3f);
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, A_PRL, 32'h0);
    apb(1'b1, A_PRC, 32'h0);
    $display("test registers done");
    apb(1'b1, A_ENC, 32'h3f);
    apb(1'b1, A_ENL, 32'h3f);
    set_flags(F_EXT0);
    no_call("global off");
    apb(1'b1, A_ENL, 32'hbe);
    no_call("source off");
    set_flags(21'h0);
    apb(1'b1, A_EDG, 32'h5);
    apb(1'b1, A_ENL, 32'hbf);
    $display("test enables done");
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, A_EDG, (j == 0) ? 32'h5 : 32'h2);
      for (int i = 0; i < 12; i++) begin
        serve(21'h1 << fbit[j][i], i, (j == 0 && i == 0) ? 3'h1 :
          (j == 0 && i == 3) ? 3'h4 : (j == 1 && i == 4) ? 3'h2 : 3'h0, 2'h1);
        set_flags(21'h0);
        do_ret(1'b0);
        check("exit level", 32'(in_progress), 32'h0);
      end
    end
    apb(1'b1, A_EDG, 32'h5);
    $display("test vectors done");
    serve(F_EXT0 | F_ADC, 0, 3'h1, 2'h1);
    set_flags(21'h0);
    do_ret(1'b0);
    serve(F_ADC | F_T0, 1, 3'h0, 2'h1);
    set_flags(21'h0);
    do_ret(1'b0);
    $display("test polling order done");
    apb(1'b1, A_PRL, 32'h2);
    serve(F_EXT0 | F_T0, 2, 3'h0, 2'h2);
    set_flags(F_EXT0);
    no_call("high blocks all");
    set_flags(21'h0);
    do_ret(1'b0);
    no_call("denied not kept");
    serve(F_EXT0, 0, 3'h1, 2'h1);
    set_flags(F_EXT0 | F_ADC);
    no_call("low on low");
    do_ret(1'b1);
    no_call("plain return");
    check("plain keeps level", 32'(in_progress), 32'h1);
    serve(F_EXT0 | F_ADC | F_T0, 2, 3'h0, 2'h3);
    apb(1'b0, A_STS, 32'h0);
    check("status levels", 32'(rd[1:0]), 32'h3);
    set_flags(21'h0);
    do_ret(1'b0);
    check("exit high first", 32'(in_progress), 32'h1);
    do_ret(1'b0);
    check("exit low", 32'(in_progress), 32'h0);
    set_flags(F_EXT0);
    irq_reg_write <= 1'b1;
    no_call("core write holds off");
    irq_reg_write <= 1'b0;
    serve(F_EXT0, 0, 3'h1, 2'h1);
    set_flags(21'h0);
    do_ret(1'b0);
    $display("test levels done");
    @(posedge pclk);
    while (fsp !== 1'b1) @(posedge pclk);
    set_flags(F_EXT0);
    set_flags(21'h0);
    no_call("flag between samples");
    $display("test sampling done");
    print_verdict();
  end
endmodule
`default_nettype wire
